// file: verilog/fcd_pkg.sv
// shared constants and types of the floating-point dispatch block
package fcd_pkg;
    // clock and coprocessor type detection timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DETECT_TIME_NS = 1000;
    localparam logic [7:0] DETECT_CYC = 8'((DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // trap vectors
    localparam logic [7:0] VEC_DEV_UNAVAIL = 8'h07;
    localparam logic [7:0] VEC_PAGE_FAULT = 8'h0e;
    localparam logic [7:0] VEC_NUMERIC = 8'h10;

    // control word readback values
    localparam logic [15:0] CW_ABSENT = 16'hffff;
    localparam logic [15:0] CW_PRESENT = 16'h037f;

    // pin sync bit positions
    localparam int PIN_ERR_N = 0;
    localparam int PIN_PRESENT = 1;
    localparam int PIN_CNT = 2;

    // instruction classes
    typedef enum logic [2:0] {
        OP_FP_ARITH = 3'b000,
        OP_FP_STORE = 3'b001,
        OP_FPU_RESET = 3'b010,
        OP_FP_STCW = 3'b011,
        OP_FPU_SYNC = 3'b100,
        OP_SERIAL = 3'b101,
        OP_OTHER = 3'b110
    } fcd_op_t;

    // controller states
    typedef enum logic [2:0] {
        ST_DETECT = 3'b000,
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b011
    } fcd_st_t;

    // instruction request
    typedef struct packed {
        fcd_op_t op;
        logic split;
        logic fault;
    } fcd_req_t;

    // machine control word flags
    typedef struct packed {
        logic soft_fpu_trap_flag;
        logic monitor_coproc_flag;
        logic numeric_error_flag;
        logic task_switched_flag;
    } fcd_flags_t;

    // whole state of the controller
    typedef struct packed {
        fcd_st_t st;
        logic [7:0] det_cnt;
        fcd_req_t req;
        logic fp_busy;
        logic pend_exc;
        logic newer;
        logic type_valid;
        logic busy;
        logic done;
        logic trap;
        logic [7:0] vec;
        logic issue;
        logic [15:0] cw_data;
        logic cw_valid;
        logic lo_we;
        logic hi_we;
    } fcd_state_t;

    localparam fcd_state_t STATE_RST = '{st: ST_DETECT, req: '{op: OP_OTHER, default: 1'b0},
                                         busy: 1'b1, default: '0};
endpackage

// file: verilog/fcd_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fcd_pin_sync
    import fcd_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pins and filtered levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } fcd_sync_t;

    fcd_sync_t s_ff;
    fcd_sync_t nxt_s;
    logic [WIDTH-1:0] nxt_lvl;

    // level follows once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign nxt_lvl[i] = (s_ff.s2[i] == s_ff.s3[i]) ? s_ff.s3[i] : s_ff.lvl[i];
    end

    // next state of the chain
    always_comb begin
        nxt_s.s1 = pin_in;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        nxt_s.lvl = nxt_lvl;
    end

    // register the chain
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level_out = s_ff.lvl;
endmodule
`default_nettype wire

// file: verilog/fcd_dispatch.sv
// floating-point instruction dispatch, synchronisation and coprocessor detection
`timescale 1ns/1ps
`default_nettype none
module fcd_dispatch
    import fcd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // instruction request
    input wire logic instr_valid,
    input wire fcd_req_t instr_req,
    input wire logic commit_pending,
    output logic instr_busy,
    output logic instr_done,
    output logic trap_valid,
    output logic [7:0] trap_vector,
    // control flags
    input wire fcd_flags_t flags,
    // floating-point unit side
    output logic fpu_issue,
    input wire logic fpu_done,
    input wire logic fpu_exc,
    output logic store_lo_we,
    output logic store_hi_we,
    output logic [15:0] cw_read_data,
    output logic cw_read_valid,
    // coprocessor pins and detection result
    input wire logic coproc_error_n,
    input wire logic coproc_present,
    output logic coproc_newer,
    output logic coproc_type_valid
);
    fcd_state_t s_ff;
    fcd_state_t nxt_s;
    logic [PIN_CNT-1:0] pin_lvl;
    logic [PIN_CNT-1:0] pins;
    logic take;
    logic fp_class;

    assign pins = {coproc_present, coproc_error_n};

    // pin synchronisers for the fault and presence lines
    fcd_pin_sync #(
        .WIDTH(PIN_CNT)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(pins),
        .level_out(pin_lvl)
    );

    assign take = (s_ff.st == ST_IDLE) && instr_valid;
    assign fp_class = (s_ff.req.op == OP_FP_ARITH) || (s_ff.req.op == OP_FP_STORE) ||
                      (s_ff.req.op == OP_FPU_RESET) || (s_ff.req.op == OP_FP_STCW);

    // next-state logic
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.trap = 1'b0;
        nxt_s.issue = 1'b0;
        nxt_s.cw_valid = 1'b0;
        nxt_s.lo_we = 1'b0;
        nxt_s.hi_we = 1'b0;
        // unit completion clears busy, a new issue below wins
        if (fpu_done) begin
            nxt_s.fp_busy = 1'b0;
        end
        // exception from the unit stays pending until reported or cleared by an fpu reset op; set wins
        if (fpu_exc) begin
            nxt_s.pend_exc = 1'b1;
        end
        case (s_ff.st)
            ST_DETECT: begin
                if (s_ff.det_cnt == DETECT_CYC - 8'h01) begin
                    nxt_s.newer = ~pin_lvl[PIN_ERR_N];
                    nxt_s.type_valid = 1'b1;
                    nxt_s.st = ST_IDLE;
                end else begin
                    nxt_s.det_cnt = s_ff.det_cnt + 8'h01;
                end
            end
            ST_IDLE: begin
                if (take) begin
                    nxt_s.req = instr_req;
                    nxt_s.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (fp_class && flags.soft_fpu_trap_flag) begin
                    // emulation: every fp op goes to the software emulator
                    nxt_s.trap = 1'b1;
                    nxt_s.vec = VEC_DEV_UNAVAIL;
                    nxt_s.st = ST_IDLE;
                end else if (s_ff.req.op == OP_FPU_SYNC && flags.monitor_coproc_flag &&
                             flags.task_switched_flag) begin
                    nxt_s.trap = 1'b1;
                    nxt_s.vec = VEC_DEV_UNAVAIL;
                    nxt_s.st = ST_IDLE;
                end else if (s_ff.fp_busy || (s_ff.req.op == OP_SERIAL && commit_pending)) begin
                    nxt_s.st = ST_WAIT;
                end else begin
                    nxt_s.st = ST_IDLE;
                    case (s_ff.req.op)
                        OP_FP_ARITH, OP_FP_STORE: begin
                            if (s_ff.pend_exc && flags.numeric_error_flag) begin
                                // late report of an exception left by an earlier op
                                nxt_s.trap = 1'b1;
                                nxt_s.vec = VEC_NUMERIC;
                                nxt_s.pend_exc = fpu_exc;
                            end else if (s_ff.req.op == OP_FP_STORE) begin
                                nxt_s.issue = 1'b1;
                                nxt_s.fp_busy = 1'b1;
                                nxt_s.lo_we = 1'b1;
                                if (s_ff.req.split && s_ff.req.fault) begin
                                    // first half already written, second half dropped
                                    nxt_s.trap = 1'b1;
                                    nxt_s.vec = VEC_PAGE_FAULT;
                                end else begin
                                    nxt_s.hi_we = 1'b1;
                                    nxt_s.done = 1'b1;
                                end
                            end else begin
                                nxt_s.issue = 1'b1;
                                nxt_s.fp_busy = 1'b1;
                                nxt_s.done = 1'b1;
                            end
                        end
                        OP_FPU_RESET: begin
                            // integrated unit: init clears pending, raises nothing
                            nxt_s.issue = 1'b1;
                            nxt_s.fp_busy = 1'b1;
                            nxt_s.pend_exc = fpu_exc; // a new exception still wins
                            nxt_s.done = 1'b1;
                        end
                        OP_FP_STCW: begin
                            nxt_s.cw_data = pin_lvl[PIN_PRESENT] ? CW_PRESENT : CW_ABSENT;
                            nxt_s.cw_valid = 1'b1;
                            nxt_s.done = 1'b1;
                        end
                        default: begin
                            // sync, serializing and other ops just complete
                            nxt_s.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                if (!s_ff.fp_busy && !(s_ff.req.op == OP_SERIAL && commit_pending)) begin
                    nxt_s.st = ST_EXEC;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
        nxt_s.busy = (nxt_s.st != ST_IDLE);
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_ff <= STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign instr_busy = s_ff.busy;
    assign instr_done = s_ff.done;
    assign trap_valid = s_ff.trap;
    assign trap_vector = s_ff.vec;
    assign fpu_issue = s_ff.issue;
    assign store_lo_we = s_ff.lo_we;
    assign store_hi_we = s_ff.hi_we;
    assign cw_read_data = s_ff.cw_data;
    assign cw_read_valid = s_ff.cw_valid;
    assign coproc_newer = s_ff.newer;
    assign coproc_type_valid = s_ff.type_valid;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_take_fp;
        take && (instr_req.op != OP_FPU_SYNC) && (instr_req.op != OP_SERIAL) && (instr_req.op != OP_OTHER);
    endsequence
    sequence s_take_sync;
        take && (instr_req.op == OP_FPU_SYNC);
    endsequence

    a_em_trap_fp: assert property (s_take_fp ##1 flags.soft_fpu_trap_flag |=>
        trap_valid && trap_vector == VEC_DEV_UNAVAIL && !fpu_issue)
        else $error("fp op not trapped to emulator");
    a_no_em_issue: assert property (fpu_issue |-> !$past(flags.soft_fpu_trap_flag))
        else $error("fp op issued while emulating");
    a_sync_ts_trap: assert property (s_take_sync ##1 (flags.monitor_coproc_flag && flags.task_switched_flag)
        |=> trap_valid && trap_vector == VEC_DEV_UNAVAIL)
        else $error("sync op with task switch not trapped");
    a_sync_ts_ignore: assert property (s_take_sync ##1 !flags.monitor_coproc_flag |=> !trap_valid)
        else $error("sync op tested task switch with monitor off");
    a_issue_after_prev: assert property (fpu_issue |-> !$past(s_ff.fp_busy))
        else $error("fp op issued before previous finished");
    a_sync_no_effect: assert property (s_take_sync |-> ##1 (!fpu_issue && !cw_read_valid)[*2])
        else $error("sync op had side effects");
    a_serial_commit: assert property (instr_done && s_ff.req.op == OP_SERIAL |-> !$past(commit_pending))
        else $error("serializing op completed with updates outstanding");
    a_detect_first: assert property (!coproc_type_valid |-> instr_busy && !fpu_issue)
        else $error("instruction accepted before type detection");
    a_split_store: assert property (store_lo_we && !store_hi_we |-> trap_valid && trap_vector == VEC_PAGE_FAULT)
        else $error("partial store without fault");
    a_reset_quiet: assert property (fpu_issue && s_ff.req.op == OP_FPU_RESET |-> !trap_valid ##1 !trap_valid)
        else $error("fpu reset op raised an error");
    a_cw_value: assert property (cw_read_valid |->
        cw_read_data == ($past(pin_lvl[PIN_PRESENT]) ? CW_PRESENT : CW_ABSENT))
        else $error("wrong control word readback");
    a_late_report: assert property (trap_valid && trap_vector == VEC_NUMERIC |->
        $past(s_ff.req.op == OP_FP_ARITH || s_ff.req.op == OP_FP_STORE))
        else $error("numeric exception reported on wrong op");
endmodule
`default_nettype wire

// file: verification/fcd_coproc_model.sv
// behavioural model of the floating-point unit and coprocessor pins
`timescale 1ns/1ps
`default_nettype none
module fcd_coproc_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bench controls
    input wire logic newer_type,
    input wire logic fitted,
    input wire logic arm_exc,
    input wire logic [7:0] lat,
    // unit side
    input wire logic fpu_issue,
    output logic fpu_done,
    output logic fpu_exc,
    // coprocessor pins
    output logic coproc_error_n,
    output logic coproc_present
);
    logic [7:0] cnt_ff;

    // newer type holds its fault line active from reset on, older type inactive
    assign coproc_error_n = ~newer_type;
    assign coproc_present = fitted;

    // the unit writes no memory itself: a faulting split operand gets nothing from this side
    // finish each issued op lat cycles later, with an exception when armed
    always_ff @(posedge clk_sys) begin
        fpu_done <= 1'b0;
        fpu_exc <= 1'b0;
        if (reset) begin
            cnt_ff <= 8'h00;
        end else if (fpu_issue) begin
            cnt_ff <= lat;
        end else if (cnt_ff == 8'h01) begin
            cnt_ff <= 8'h00;
            fpu_done <= 1'b1;
            fpu_exc <= arm_exc;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the floating-point dispatch block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fcd_pkg::*;
;
    // stimulus and observed signals
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    fcd_req_t instr_req = '{op: OP_OTHER, default: 1'b0};
    logic commit_pending = 1'b0;
    fcd_flags_t flags = '0;
    logic newer_type = 1'b1;
    logic fitted = 1'b1;
    logic arm_exc = 1'b0;
    logic [7:0] lat = 8'h01;
    logic instr_busy, instr_done, trap_valid, fpu_issue, fpu_done, fpu_exc, store_lo_we, store_hi_we;
    logic cw_read_valid, coproc_error_n, coproc_present, coproc_newer, coproc_type_valid;
    logic [7:0] trap_vector;
    logic [15:0] cw_read_data;
    logic r_done, r_trap, r_issue, r_lo, r_hi, r_cwv, r_fd;
    logic [7:0] r_vec;
    logic [15:0] r_cw;
    int r_cyc;
    // machine control word image and the masks software applies to it
    logic [31:0] mcw;
    localparam logic [31:0] MCW_MP_CLR = 32'hfffffffd;
    localparam logic [31:0] MCW_EM_NE_SET = 32'h00000024;
    int fails = 0;
    int total_checks = 0;

    // 100 ns clock
    always #50 clk_sys = ~clk_sys;

    fcd_dispatch dut (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr_req(instr_req),
        .commit_pending(commit_pending), .instr_busy(instr_busy), .instr_done(instr_done),
        .trap_valid(trap_valid), .trap_vector(trap_vector), .flags(flags), .fpu_issue(fpu_issue),
        .fpu_done(fpu_done), .fpu_exc(fpu_exc), .store_lo_we(store_lo_we), .store_hi_we(store_hi_we),
        .cw_read_data(cw_read_data), .cw_read_valid(cw_read_valid), .coproc_error_n(coproc_error_n),
        .coproc_present(coproc_present), .coproc_newer(coproc_newer), .coproc_type_valid(coproc_type_valid));

    fcd_coproc_model unit (.clk_sys(clk_sys), .reset(reset), .newer_type(newer_type), .fitted(fitted),
        .arm_exc(arm_exc), .lat(lat), .fpu_issue(fpu_issue), .fpu_done(fpu_done), .fpu_exc(fpu_exc),
        .coproc_error_n(coproc_error_n), .coproc_present(coproc_present));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t ns %s", $time, msg);
        end
    endtask

    // reset, then wait for type detection to finish
    task automatic do_reset(input logic nw);
        newer_type = nw;
        reset = 1'b1;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        for (int i = 0; i < 40 && instr_busy !== 1'b0; i++) @(negedge clk_sys);
        chk(coproc_type_valid === 1'b1 && coproc_newer === nw, "type detection wrong");
    endtask

    // one request, gathering every pulse until completion or trap
    task automatic exec(input fcd_op_t op, input logic split, input logic fault);
        {r_done, r_trap, r_issue, r_lo, r_hi, r_cwv, r_fd} = '0;
        r_cyc = 0;
        instr_req = '{op: op, split: split, fault: fault};
        instr_valid = 1'b1;
        @(negedge clk_sys);
        instr_valid = 1'b0;
        while (r_done !== 1'b1 && r_trap !== 1'b1 && r_cyc < 200) begin
            @(negedge clk_sys);
            r_cyc++;
            r_done = instr_done;
            r_trap = trap_valid;
            r_issue = r_issue | fpu_issue;
            r_lo = r_lo | store_lo_we;
            r_hi = r_hi | store_hi_we;
            r_fd = r_fd | fpu_done;
            r_cwv = r_cwv | cw_read_valid;
            r_cw = cw_read_data;
            r_vec = trap_vector;
        end
    endtask

    // leave an unmasked exception pending in the dispatcher
    task automatic make_exc();
        exec(OP_FPU_SYNC, 1'b0, 1'b0); // drain the unit so only the armed op raises an exception
        arm_exc = 1'b1;
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_issue === 1'b1 && r_done === 1'b1, "arming op not issued");
        exec(OP_FPU_SYNC, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_trap === 1'b0, "sync op reported the exception");
        arm_exc = 1'b0;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        conclude();
    end

    // test sequence
    initial begin
        do_reset(1'b1);
        do_reset(1'b0);
        $display("test detect done");
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 4; k++) begin
                flags.soft_fpu_trap_flag = e[0];
                exec(fcd_op_t'(k), 1'b0, 1'b0);
                chk(r_trap === e[0] && r_done === ~e[0], "dispatch or trap wrong");
                if (e == 1) chk(r_vec === VEC_DEV_UNAVAIL && r_issue === 1'b0, "emulation trap wrong");
            end
        end
        $display("test emulate done");
        for (int m = 0; m < 4; m++) begin
            flags = '{soft_fpu_trap_flag: m[1], monitor_coproc_flag: m[0], default: 1'b1};
            flags.numeric_error_flag = 1'b0;
            exec(OP_FPU_SYNC, 1'b0, 1'b0);
            chk(r_trap === m[0] && (r_vec === VEC_DEV_UNAVAIL || !m[0]), "task switch test wrong");
        end
        $display("test monitor done");
        flags = '0;
        lat = 8'h08;
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_fd === 1'b1 && r_issue === 1'b1 && r_done === 1'b1, "second op did not wait");
        exec(OP_FPU_SYNC, 1'b0, 1'b0);
        chk(r_fd === 1'b1 && r_done === 1'b1 && r_issue === 1'b0, "sync op wrong");
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_issue === 1'b1 && r_fd === 1'b0, "op after sync wrong");
        $display("test sync done");
        lat = 8'h03;
        exec(OP_FP_STORE, 1'b1, 1'b0);
        chk(r_lo === 1'b1 && r_hi === 1'b1 && r_done === 1'b1, "whole store wrong");
        exec(OP_FP_STORE, 1'b1, 1'b1);
        chk(r_lo === 1'b1 && r_hi === 1'b0 && r_vec === VEC_PAGE_FAULT, "split fault store wrong");
        $display("test store done");
        for (int p = 0; p < 2; p++) begin
            fitted = p[0];
            repeat (8) @(negedge clk_sys);
            exec(OP_FP_STCW, 1'b0, 1'b0);
            chk(r_cwv === 1'b1 && r_cw === (p[0] ? CW_PRESENT : CW_ABSENT), "control word wrong");
        end
        $display("test control word done");
        commit_pending = 1'b1;
        fork
            exec(OP_SERIAL, 1'b0, 1'b0);
            begin
                repeat (6) @(negedge clk_sys);
                commit_pending = 1'b0;
            end
        join
        chk(r_done === 1'b1 && r_cyc > 5, "serial op did not wait");
        $display("test serial done");
        flags.numeric_error_flag = 1'b1;
        make_exc();
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_trap === 1'b1 && r_vec === VEC_NUMERIC, "pending exception not reported");
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_trap === 1'b0, "exception reported twice");
        make_exc();
        exec(OP_FPU_RESET, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_trap === 1'b0, "fpu reset op raised error");
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_trap === 1'b0, "error left after fpu reset op");
        $display("test exception done");
        // no coprocessor: masks clear monitor, set trap and numeric flags
        fitted = 1'b0;
        mcw = (32'h00000002 & MCW_MP_CLR) | MCW_EM_NE_SET;
        flags = '{soft_fpu_trap_flag: (mcw & MCW_EM_NE_SET) == MCW_EM_NE_SET, monitor_coproc_flag: mcw[1],
                  numeric_error_flag: (mcw & MCW_EM_NE_SET) == MCW_EM_NE_SET, task_switched_flag: 1'b1};
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_trap === 1'b1 && r_vec === VEC_DEV_UNAVAIL && r_issue === 1'b0, "no coprocessor setup wrong");
        exec(OP_FPU_SYNC, 1'b0, 1'b0);
        chk(r_done === 1'b1 && r_trap === 1'b0, "sync op tested task switch");
        // coprocessor fitted: trap flag off, monitor on
        fitted = 1'b1;
        flags = '{soft_fpu_trap_flag: 1'b0, monitor_coproc_flag: 1'b1, numeric_error_flag: 1'b1,
                  task_switched_flag: 1'b0};
        repeat (8) @(negedge clk_sys);
        exec(OP_FP_STCW, 1'b0, 1'b0);
        chk(r_cwv === 1'b1 && r_cw === CW_PRESENT, "coprocessor setup readback wrong");
        exec(OP_FP_ARITH, 1'b0, 1'b0);
        chk(r_issue === 1'b1 && r_done === 1'b1, "coprocessor setup dispatch wrong");
        $display("test setup done");
        conclude();
    end
endmodule
`default_nettype wire
